/* File: logic/dcvfc_map.svh */
/*
 daisy-chain valid frame counter register map: word indices, field
 positions, reset values and bus timing for the counter bank.
 assumes the includer multiplies an index by four to form a byte address.
*/
// Function
// - upper port command frame counts only when error-free and crc good
// - upper port 16-bit count holds at 0xFFFF, never wraps
// - reading upper low byte clears it and zeroes the upper counter
// - reading upper high byte latches all upper statistics together
// - lower port response counter exists; high byte has own read-only register
// - lower port 16-bit count holds at 0xFFFF, never rolls over
// - reading lower third statistics register latches lower bytes, then zeroes counter
// - upper low byte at 0x276, 8 bits, read-only, resets to zero
// - lower high byte at 0x277, 8 bits, read-only, resets to zero
// - upper high byte at 0x275 holds upper eight count bits
// - lower low byte at 0x278 completes the lower 16-bit count
`ifndef DCVFC_MAP_SVH
`define DCVFC_MAP_SVH

`define DCVFC_ADDR_W 12
`define DCVFC_DATA_W 32
`define DCVFC_CNT_W 16

`define DCVFC_IDX_UPPER_HI 10'h275
`define DCVFC_IDX_UPPER_LO 10'h276
`define DCVFC_IDX_LOWER_HI 10'h277
`define DCVFC_IDX_LOWER_LO 10'h278
`define DCVFC_IDX_LOWER_THIRD 10'h2F0
`define DCVFC_IDX_CTRL 10'h2F1
`define DCVFC_IDX_STATUS 10'h2F2
`define DCVFC_IDX_LIVE 10'h2F3

`define DCVFC_BYTE_RST 8'h00
`define DCVFC_CNT_FULL 16'hFFFF
`define DCVFC_CTRL_RST 2'h3
`define DCVFC_CTRL_UPPER_EN 0
`define DCVFC_CTRL_LOWER_EN 1
`define DCVFC_STAT_UPPER_SAT 0
`define DCVFC_STAT_LOWER_SAT 1
`define DCVFC_STAT_UPPER_HELD 2

`define DCVFC_WAIT_CYCLES 1

`endif

/* File: logic/dcvfc_pkg.sv */
/*
 types shared by the counter bank: bus phase and register select codes.
 assumes dcvfc_map.svh carries every numeric constant.
*/
`default_nettype none
package dcvfc_pkg;
   typedef enum logic [2:0] {
      APB_IDLE  = 3'b001,
      APB_WAIT  = 3'b010,
      APB_READY = 3'b100
   } dcvfc_apb_state_type;

   typedef enum logic [8:0] {
      SEL_NONE        = 9'h001,
      SEL_UPPER_HI    = 9'h002,
      SEL_UPPER_LO    = 9'h004,
      SEL_LOWER_HI    = 9'h008,
      SEL_LOWER_LO    = 9'h010,
      SEL_LOWER_THIRD = 9'h020,
      SEL_CTRL        = 9'h040,
      SEL_STATUS      = 9'h080,
      SEL_LIVE        = 9'h100
   } dcvfc_sel_type;
endpackage
`default_nettype wire

/* File: logic/dcvfc_sat_counter.sv */
/*
 16-bit saturating frame counter with a synchronous period restart.
 assumes inc_i is a one-cycle pulse per qualifying frame.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcvfc_map.svh"
module dcvfc_sat_counter (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // control
   input wire logic inc_i,
   input wire logic restart_i,
   // state
   output logic [`DCVFC_CNT_W-1:0] count_o,
   output logic full_o
);
   logic [`DCVFC_CNT_W-1:0] count_r;

   assign full_o = (count_r == `DCVFC_CNT_FULL);
   assign count_o = count_r;

   // a frame landing on the restart edge opens the new period, not lost
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         count_r <= '0;
      end else if (restart_i) begin
         count_r <= inc_i ? `DCVFC_CNT_W'(1) : '0;
      end else if (inc_i && !full_o) begin
         count_r <= count_r + `DCVFC_CNT_W'(1);
      end
   end
endmodule
`default_nettype wire

/* File: logic/dcvfc_apb_if.sv */
/*
 apb3 slave handshake: one wait cycle, then pready for one cycle.
 assumes the master holds the request until pready is sampled high.
*/
`timescale 1ns/1ps
`default_nettype none
module dcvfc_apb_if (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // bus request
   input wire logic psel_i,
   input wire logic penable_i,
   // bus answer
   output logic pready_o,
   // strobes to the register file
   output logic load_o,
   output logic done_o
);
   dcvfc_pkg::dcvfc_apb_state_type state_r;
   dcvfc_pkg::dcvfc_apb_state_type state_nxt;

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         dcvfc_pkg::APB_IDLE: begin
            if (psel_i && penable_i) state_nxt = dcvfc_pkg::APB_READY;
         end
         dcvfc_pkg::APB_READY: state_nxt = dcvfc_pkg::APB_IDLE;
         dcvfc_pkg::APB_WAIT: state_nxt = dcvfc_pkg::APB_IDLE;
      endcase
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         state_r <= dcvfc_pkg::APB_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // read data is sampled one edge before completion so it comes from a flop
   assign load_o = (state_r == dcvfc_pkg::APB_IDLE) && psel_i && penable_i;
   assign pready_o = (state_r == dcvfc_pkg::APB_READY);
   assign done_o = pready_o && psel_i && penable_i;
endmodule
`default_nettype wire

/* File: logic/dcvfc_top.sv */
/*
 daisy-chain valid frame counter bank: two saturating 16-bit counters
 (upper port commands, lower port responses), snapshot byte registers,
 a control and a status word, all on an apb3 slave.
 assumes frame status pulses are synchronous to clock_i, one cycle each.
*/
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "dcvfc_map.svh"
module dcvfc_top (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // apb3 slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [`DCVFC_ADDR_W-1:0] paddr_i,
   input wire logic [`DCVFC_DATA_W-1:0] pwdata_i,
   output logic [`DCVFC_DATA_W-1:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // upper chain port frame status
   input wire logic upper_frame_done_i,
   input wire logic upper_frame_err_i,
   input wire logic upper_frame_crc_ok_i,
   // lower chain port frame status
   input wire logic lower_frame_done_i,
   input wire logic lower_frame_err_i,
   input wire logic lower_frame_crc_ok_i,
   // saturation indicators
   output logic upper_count_sat_o,
   output logic lower_count_sat_o
);
   // bus strobes
   logic load;
   logic done;
   logic rd_done;
   logic wr_done;

   // decode
   dcvfc_pkg::dcvfc_sel_type sel;
   logic [9:0] word_idx;
   logic aligned;

   // control and status
   logic [1:0] ctrl_r;
   logic upper_sat_r;
   logic lower_sat_r;
   logic upper_held_r;

   // frame qualification
   logic upper_good;
   logic lower_good;
   logic upper_inc;
   logic lower_inc;

   // live counters
   logic [`DCVFC_CNT_W-1:0] upper_count;
   logic [`DCVFC_CNT_W-1:0] lower_count;
   logic upper_full;
   logic lower_full;
   logic upper_restart;
   logic lower_restart;

   // snapshot bytes
   logic [7:0] upper_lo_r;
   logic [7:0] lower_hi_r;
   logic [7:0] lower_lo_r;
   logic [7:0] upper_cap_lo_r;

   // read path
   logic [`DCVFC_DATA_W-1:0] rd_mux;
   logic rd_err;
   logic [`DCVFC_DATA_W-1:0] prdata_r;
   logic err_r;
   dcvfc_pkg::dcvfc_sel_type sel_r;
   logic write_r;

   dcvfc_apb_if u_apb (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pready_o(pready_o),
      .load_o(load),
      .done_o(done)
   );

   assign word_idx = paddr_i[11:2];
   assign aligned = (paddr_i[1:0] == 2'h0);

   // printed offsets are word indices; byte address is four times each
   always_comb begin
      sel = dcvfc_pkg::SEL_NONE;
      if (aligned) begin
         unique case (word_idx)
            `DCVFC_IDX_UPPER_HI: sel = dcvfc_pkg::SEL_UPPER_HI;
            `DCVFC_IDX_UPPER_LO: sel = dcvfc_pkg::SEL_UPPER_LO;
            `DCVFC_IDX_LOWER_HI: sel = dcvfc_pkg::SEL_LOWER_HI;
            `DCVFC_IDX_LOWER_LO: sel = dcvfc_pkg::SEL_LOWER_LO;
            `DCVFC_IDX_LOWER_THIRD: sel = dcvfc_pkg::SEL_LOWER_THIRD;
            `DCVFC_IDX_CTRL: sel = dcvfc_pkg::SEL_CTRL;
            `DCVFC_IDX_STATUS: sel = dcvfc_pkg::SEL_STATUS;
            `DCVFC_IDX_LIVE: sel = dcvfc_pkg::SEL_LIVE;
            default: sel = dcvfc_pkg::SEL_NONE;
         endcase
      end
   end

   // read data for the access phase; hi byte of upper port reads live count
   always_comb begin
      rd_mux = '0;
      rd_err = 1'b0;
      unique case (sel)
         dcvfc_pkg::SEL_UPPER_HI: begin
            rd_mux[7:0] = upper_count[15:8];
            rd_err = pwrite_i;
         end
         dcvfc_pkg::SEL_UPPER_LO: begin
            rd_mux[7:0] = upper_lo_r;
            rd_err = pwrite_i;
         end
         dcvfc_pkg::SEL_LOWER_HI: begin
            rd_mux[7:0] = lower_hi_r;
            rd_err = pwrite_i;
         end
         dcvfc_pkg::SEL_LOWER_LO: begin
            rd_mux[7:0] = lower_lo_r;
            rd_err = pwrite_i;
         end
         dcvfc_pkg::SEL_LOWER_THIRD: begin
            rd_err = pwrite_i;
         end
         dcvfc_pkg::SEL_CTRL: begin
            rd_mux[1:0] = ctrl_r;
         end
         dcvfc_pkg::SEL_STATUS: begin
            rd_mux[`DCVFC_STAT_UPPER_SAT] = upper_sat_r;
            rd_mux[`DCVFC_STAT_LOWER_SAT] = lower_sat_r;
            rd_mux[`DCVFC_STAT_UPPER_HELD] = upper_held_r;
         end
         dcvfc_pkg::SEL_LIVE: begin
            rd_mux = {lower_count, upper_count};
            rd_err = pwrite_i;
         end
         dcvfc_pkg::SEL_NONE: begin
            rd_err = 1'b1;
         end
      endcase
   end

   // request captured one edge before pready so data comes from flops
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         prdata_r <= '0;
         err_r <= 1'b0;
         sel_r <= dcvfc_pkg::SEL_NONE;
         write_r <= 1'b0;
      end else if (load) begin
         prdata_r <= pwrite_i ? '0 : rd_mux;
         err_r <= rd_err;
         sel_r <= sel;
         write_r <= pwrite_i;
      end
   end

   assign prdata_o = prdata_r;
   assign pslverr_o = pready_o && err_r;

   // refused accesses have no side effects
   assign rd_done = done && !write_r && !err_r;
   assign wr_done = done && write_r && !err_r;

   // low byte of the upper high read, kept so the pair matches what was returned
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         upper_cap_lo_r <= `DCVFC_BYTE_RST;
      end else if (load && sel == dcvfc_pkg::SEL_UPPER_HI) begin
         upper_cap_lo_r <= upper_count[7:0];
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         ctrl_r <= `DCVFC_CTRL_RST;
      end else if (wr_done && sel_r == dcvfc_pkg::SEL_CTRL) begin
         ctrl_r <= pwdata_i[1:0];
      end
   end

   // frame qualification
   assign upper_good = upper_frame_done_i && !upper_frame_err_i && upper_frame_crc_ok_i;
   assign lower_good = lower_frame_done_i && !lower_frame_err_i && lower_frame_crc_ok_i;
   assign upper_inc = upper_good && ctrl_r[`DCVFC_CTRL_UPPER_EN];
   assign lower_inc = lower_good && ctrl_r[`DCVFC_CTRL_LOWER_EN];

   // period restart: upper on low-byte read, lower on third register read
   assign upper_restart = rd_done && sel_r == dcvfc_pkg::SEL_UPPER_LO;
   assign lower_restart = rd_done && sel_r == dcvfc_pkg::SEL_LOWER_THIRD;

   dcvfc_sat_counter u_upper_cnt (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .inc_i(upper_inc),
      .restart_i(upper_restart),
      .count_o(upper_count),
      .full_o(upper_full)
   );

   dcvfc_sat_counter u_lower_cnt (
      .clock_i(clock_i),
      .sys_rst_i(sys_rst_i),
      .inc_i(lower_inc),
      .restart_i(lower_restart),
      .count_o(lower_count),
      .full_o(lower_full)
   );

   // upper snapshot: high byte goes straight out on its read, so only the low byte is kept
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         upper_lo_r <= `DCVFC_BYTE_RST;
      end else if (rd_done && sel_r == dcvfc_pkg::SEL_UPPER_HI) begin
         upper_lo_r <= upper_cap_lo_r;
      end else if (upper_restart) begin
         upper_lo_r <= `DCVFC_BYTE_RST;
      end
   end

   // snapshot held from high read until the low byte is taken
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         upper_held_r <= 1'b0;
      end else if (rd_done && sel_r == dcvfc_pkg::SEL_UPPER_HI) begin
         upper_held_r <= 1'b1;
      end else if (upper_restart) begin
         upper_held_r <= 1'b0;
      end
   end

   // lower snapshot: both bytes taken on the same edge that restarts the count
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         lower_hi_r <= `DCVFC_BYTE_RST;
         lower_lo_r <= `DCVFC_BYTE_RST;
      end else if (lower_restart) begin
         lower_hi_r <= lower_count[15:8];
         lower_lo_r <= lower_count[7:0];
      end
   end

   // sticky saturation flags, write one to clear; saturation wins the clear
   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         upper_sat_r <= 1'b0;
      end else if (upper_full) begin
         upper_sat_r <= 1'b1;
      end else if (wr_done && sel_r == dcvfc_pkg::SEL_STATUS && pwdata_i[`DCVFC_STAT_UPPER_SAT]) begin
         upper_sat_r <= 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (sys_rst_i) begin
         lower_sat_r <= 1'b0;
      end else if (lower_full) begin
         lower_sat_r <= 1'b1;
      end else if (wr_done && sel_r == dcvfc_pkg::SEL_STATUS && pwdata_i[`DCVFC_STAT_LOWER_SAT]) begin
         lower_sat_r <= 1'b0;
      end
   end

   assign upper_count_sat_o = upper_sat_r;
   assign lower_count_sat_o = lower_sat_r;
endmodule
`default_nettype wire

/* File: tb/dcvfc_monitor.sv */
/*
 bus, reset and read-only checks on the counter bank ports.
 assumes the bind below and the indices of dcvfc_map.svh.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcvfc_map.svh"
module dcvfc_monitor (
   // clock and reset
   input wire logic clock_i,
   input wire logic sys_rst_i,
   // apb3
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [`DCVFC_ADDR_W-1:0] paddr_i,
   input wire logic [`DCVFC_DATA_W-1:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   // saturation
   input wire logic upper_count_sat_o,
   input wire logic lower_count_sat_o
);
   logic done;
   logic [9:0] idx;
   assign done = psel_i && penable_i && pready_o;
   assign idx = paddr_i[11:2];
   default clocking mon_cb @(posedge clock_i);
   endclocking
   AST_ONE_WAIT: assert property (disable iff (sys_rst_i)
      psel_i && penable_i && !pready_o |=> pready_o)
      else $error("ready late");
   AST_READY_PULSE: assert property (disable iff (sys_rst_i) pready_o |=> !pready_o)
      else $error("ready too long");
   AST_ERR_READY: assert property (disable iff (sys_rst_i)
      pslverr_o |-> pready_o && prdata_o == 32'h0)
      else $error("stray error");
   AST_RO_UPPER_LO: assert property (disable iff (sys_rst_i)
      done && pwrite_i && idx == `DCVFC_IDX_UPPER_LO |-> pslverr_o)
      else $error("write to upper low taken");
   AST_RO_LOWER_HI: assert property (disable iff (sys_rst_i)
      done && pwrite_i && idx == `DCVFC_IDX_LOWER_HI |-> pslverr_o)
      else $error("write to lower high taken");
   AST_BYTE_WIDE: assert property (disable iff (sys_rst_i)
      done && !pwrite_i && idx >= `DCVFC_IDX_UPPER_HI && idx <= `DCVFC_IDX_LOWER_LO |-> prdata_o[31:8] == 24'h0)
      else $error("byte register too wide");
   AST_THIRD_ZERO: assert property (disable iff (sys_rst_i)
      done && !pwrite_i && idx == `DCVFC_IDX_LOWER_THIRD |-> prdata_o == 32'h0)
      else $error("trigger read not zero");
   AST_RESET_CLEARS: assert property (sys_rst_i |=> prdata_o == 32'h0 && !pready_o
      && !upper_count_sat_o && !lower_count_sat_o)
      else $error("reset state wrong");
   AST_UPPER_SAT_HOLDS: assert property (disable iff (sys_rst_i)
      upper_count_sat_o && !(done && pwrite_i) |=> upper_count_sat_o)
      else $error("upper saturation lost");
   AST_LOWER_SAT_HOLDS: assert property (disable iff (sys_rst_i)
      lower_count_sat_o && !(done && pwrite_i) |=> lower_count_sat_o)
      else $error("lower saturation lost");
   cover property (done && !pwrite_i && idx == `DCVFC_IDX_UPPER_LO);
   cover property (pslverr_o);
   cover property ($rose(upper_count_sat_o));
   cover property (done && pwrite_i && !pslverr_o);
endmodule
bind dcvfc_top dcvfc_monitor u_dcvfc_monitor (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
   .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .upper_count_sat_o(upper_count_sat_o), .lower_count_sat_o(lower_count_sat_o));
`default_nettype wire

/* File: tb/dcvfc_chain_peer.sv */
/*
 far-side model: neighbours on both chain ports ending frames.
 assumes the bench calls send between bus transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module dcvfc_chain_peer (
   // clock
   input wire logic clock_i,
   // upper port frame status
   output logic u_done_o = 1'h0,
   output logic u_err_o = 1'h0,
   output logic u_crc_o = 1'h0,
   // lower port frame status
   output logic l_done_o = 1'h0,
   output logic l_err_o = 1'h0,
   output logic l_crc_o = 1'h0
);
   task automatic send(input logic [1:0] port, input logic err, input logic crc, input int n);
      repeat (n) begin
         @(posedge clock_i);
         {u_done_o, l_done_o} <= {port[0], port[1]};
         {u_err_o, l_err_o, u_crc_o, l_crc_o} <= {err, err, crc, crc};
      end
      @(posedge clock_i);
      {u_done_o, l_done_o} <= 2'h0;
      // qualifiers flip when idle; done stays low, so a flipped pair that looks valid is not counted
      {u_err_o, l_err_o, u_crc_o, l_crc_o} <= ~{err, err, crc, crc};
   endtask
endmodule
`default_nettype wire

/* File: tb/dcvfc_top_tb.sv */
/*
 self-checking bench for the counter bank: apb master, random frames.
 assumes dcvfc_chain_peer and the bound dcvfc_monitor.
*/
`timescale 1ns/1ps
`default_nettype none
`include "dcvfc_map.svh"
module dcvfc_top_tb;
   logic clock_i = 1'h0;
   logic sys_rst_i = 1'h1;
   logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, usat, lsat, er;
   logic ud, ue, uc, ld, le, lc;
   logic [`DCVFC_ADDR_W-1:0] paddr = 12'h0;
   logic [`DCVFC_DATA_W-1:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] exp_u = 16'h0, exp_l = 16'h0;
   int err_total = 0, check_count = 0;
   always #5 clock_i = ~clock_i;
   dcvfc_chain_peer u_dcvfc_chain_peer (.clock_i(clock_i), .u_done_o(ud), .u_err_o(ue), .u_crc_o(uc),
      .l_done_o(ld), .l_err_o(le), .l_crc_o(lc));
   dcvfc_top u_dcvfc_top (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .upper_frame_done_i(ud), .upper_frame_err_i(ue), .upper_frame_crc_ok_i(uc),
      .lower_frame_done_i(ld), .lower_frame_err_i(le), .lower_frame_crc_ok_i(lc),
      .upper_count_sat_o(usat), .lower_count_sat_o(lsat));
   function automatic logic [15:0] sat_add(input logic [15:0] c, input int n);
      return (int'(c) + n > 32'hFFFF) ? 16'hFFFF : 16'(int'(c) + n);
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      int t;
      t = 0;
      @(posedge clock_i);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= wd;
      @(posedge clock_i);
      penable <= 1'h1;
      do begin
         @(posedge clock_i);
         t++;
      end while (pready !== 1'h1 && t < 50);
      if (t >= 50) begin
         err_total++;
         $display("BAD %0t no ready", $time);
         print_verdict();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'h0, idx, 32'h0);
      chk(rd, exp);
      chk({31'h0, er}, 32'h0);
   endtask
   task automatic wchk(input logic [9:0] idx, input logic [31:0] wd);
      apb(1'h1, idx, wd);
      chk({31'h0, er}, 32'h0);
   endtask
   task automatic refuse(input logic wr, input logic [9:0] idx);
      apb(wr, idx, 32'hFF);
      chk({31'h0, er}, 32'h1);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (90000) @(posedge clock_i);
      err_total++;
      $display("BAD %0t watchdog", $time);
      print_verdict();
   end
   initial begin
      logic [1:0] pm;
      logic e, c;
      int n;
      void'($urandom(49551));
      repeat (8) @(posedge clock_i);
      sys_rst_i <= 1'h0;
      for (int i = 0; i < 4; i++) rchk(`DCVFC_IDX_UPPER_HI + 10'(i), 32'h0);
      rchk(`DCVFC_IDX_CTRL, 32'h3);
      rchk(`DCVFC_IDX_STATUS, 32'h0);
      $display("test reset values done");
      // first four frames walk every err and crc combination
      for (int i = 0; i < 44; i++) begin
         pm = (i < 4) ? 2'h3 : 2'(1 + $urandom % 3);
         {e, c} = (i < 4) ? 2'(i) : 2'($urandom);
         n = (i < 4) ? 1 : 1 + $urandom % 3;
         u_dcvfc_chain_peer.send(pm, e, c, n);
         if (!e && c && pm[0]) exp_u = sat_add(exp_u, n);
         if (!e && c && pm[1]) exp_l = sat_add(exp_l, n);
      end
      rchk(`DCVFC_IDX_UPPER_HI, {24'h0, exp_u[15:8]});
      u_dcvfc_chain_peer.send(2'h1, 1'h0, 1'h1, 1);
      rchk(`DCVFC_IDX_UPPER_LO, {24'h0, exp_u[7:0]});
      rchk(`DCVFC_IDX_UPPER_LO, 32'h0);
      rchk(`DCVFC_IDX_LIVE, {exp_l, 16'h0});
      rchk(`DCVFC_IDX_LOWER_THIRD, 32'h0);
      rchk(`DCVFC_IDX_LOWER_HI, {24'h0, exp_l[15:8]});
      rchk(`DCVFC_IDX_LOWER_LO, {24'h0, exp_l[7:0]});
      rchk(`DCVFC_IDX_LIVE, 32'h0);
      $display("test random frames done");
      for (int i = 0; i < 4; i++) refuse(1'h1, `DCVFC_IDX_UPPER_HI + 10'(i));
      refuse(1'h0, 10'h000);
      rchk(`DCVFC_IDX_LIVE, 32'h0);
      $display("test refusals done");
      u_dcvfc_chain_peer.send(2'h3, 1'h0, 1'h1, 65537);
      chk({30'h0, usat, lsat}, 32'h3);
      rchk(`DCVFC_IDX_LIVE, 32'hFFFF_FFFF);
      // a clear while still full must lose to the set
      wchk(`DCVFC_IDX_STATUS, 32'h3);
      rchk(`DCVFC_IDX_STATUS, 32'h3);
      rchk(`DCVFC_IDX_UPPER_HI, 32'hFF);
      rchk(`DCVFC_IDX_STATUS, 32'h7);
      rchk(`DCVFC_IDX_UPPER_LO, 32'hFF);
      rchk(`DCVFC_IDX_LOWER_THIRD, 32'h0);
      rchk(`DCVFC_IDX_LOWER_HI, 32'hFF);
      rchk(`DCVFC_IDX_LOWER_LO, 32'hFF);
      rchk(`DCVFC_IDX_STATUS, 32'h3);
      wchk(`DCVFC_IDX_STATUS, 32'h3);
      rchk(`DCVFC_IDX_STATUS, 32'h0);
      chk({30'h0, usat, lsat}, 32'h0);
      $display("test saturation done");
      wchk(`DCVFC_IDX_CTRL, 32'h1);
      rchk(`DCVFC_IDX_CTRL, 32'h1);
      u_dcvfc_chain_peer.send(2'h3, 1'h0, 1'h1, 5);
      rchk(`DCVFC_IDX_LIVE, 32'h0000_0005);
      wchk(`DCVFC_IDX_CTRL, 32'h3);
      $display("test count enable done");
      print_verdict();
   end
endmodule
`default_nettype wire
